// >>> logic/uhcr_pkg.sv
// Constants shared by both ends of the host controller register port
package uhcr_pkg;
    // Register byte offsets
    localparam logic [15:0] OFS_CAPABILITY_PARAMETERS = 16'h0008;
    localparam logic [15:0] OFS_CONTROLLER_COMMAND    = 16'h0020;
    localparam logic [15:0] OFS_CONTROLLER_STATUS     = 16'h0024;
    localparam logic [15:0] OFS_INTERRUPT_ENABLE      = 16'h0028;
    // Capability fields
    localparam int          CAP_EXT_PTR_LSB  = 8;
    localparam int          CAP_ISO_LSB      = 4;
    localparam int          CAP_PARK_BIT     = 2;
    localparam int          CAP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT     = 1;
    localparam logic [7:0]  RST_EXT_PTR      = 8'h00;
    localparam logic [3:0]  RST_ISO_THRESH   = 4'h8;
    localparam logic [31:0] RST_CAPABILITY   = 32'h0000_0086;
    // Command fields
    localparam int          CMD_RUN_BIT      = 0;
    localparam int          CMD_RESET_BIT    = 1;
    localparam int          CMD_FLS_LSB      = 2;
    localparam int          CMD_LIGHT_BIT    = 7;
    localparam logic [31:0] RST_COMMAND      = 32'h0008_0B00;
    localparam logic [31:0] CMD_KEEP_MASK    = 32'hFFFF_FF00;
    // Status fields
    localparam int          STS_PORT_BIT     = 2;
    localparam int          STS_ROLL_BIT     = 3;
    localparam logic [31:0] RST_STATUS       = 32'h0000_0000;
    localparam logic [31:0] RST_INTR_ENABLE  = 32'h0000_0000;
endpackage : uhcr_pkg

// >>> logic/uhcr_if.sv
// Register port joining software end and controller end
`timescale 1ns/1ps
interface uhcr_if;
    logic        wrStb;
    logic        rdStb;
    logic [15:0] addr;
    logic [31:0] wrData;
    logic [31:0] rdData;
    logic        rdValid;
    modport ctrl (input wrStb, rdStb, addr, wrData, output rdData, rdValid);
    modport sw   (output wrStb, rdStb, addr, wrData, input rdData, rdValid);
endinterface : uhcr_if

// >>> logic/uhcr_ctrl_regs.sv
// Controller end: capability, command, status and enable registers
`timescale 1ns/1ps
module uhcr_ctrl_regs #(
    parameter bit LIGHT_RESET_IMPL = 1'b1
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Register port
    uhcr_if.ctrl            bus,
    // Core events, same clock
    input  wire logic       indexWrap,
    input  wire logic       portChange,
    input  wire logic       resumeDetect,
    // Core controls
    output logic            runSchedule,
    output logic [1:0]      frameListSize,
    output logic            coreReset,
    output logic            lightReset
);
    // Register images
    logic [31:0] command;
    logic [31:0] status;
    logic [31:0] intrEnable;
    logic        rollFlag;
    logic        portFlag;
    // Decoded strobes
    logic        cmdWrite;
    logic        stsWrite;
    logic        intrWrite;
    logic        doReset;
    logic        doLight;
    logic        anyReset;
    // Next values
    logic        next_rollFlag;
    logic        next_portFlag;
    logic [31:0] next_command;

    // Address match against one register offset
    function automatic logic hitReg(input logic [15:0] a, input logic [15:0] ofs);
        hitReg = (a == ofs);
    endfunction : hitReg

    // Sticky flag update: event sets, written one clears, set wins
    function automatic logic stickyFlag(
        input logic cur,
        input logic setEvt,
        input logic clrWr
    );
        if (setEvt) begin
            stickyFlag = 1'b1;
        end else if (clrWr) begin
            stickyFlag = 1'b0;
        end else begin
            stickyFlag = cur;
        end
    endfunction : stickyFlag

    // Capability word built field by field, reserved bits zero
    function automatic logic [31:0] capWord();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[uhcr_pkg::CAP_EXT_PTR_LSB +: 8] = uhcr_pkg::RST_EXT_PTR;
        w[uhcr_pkg::CAP_ISO_LSB +: 4] = uhcr_pkg::RST_ISO_THRESH;
        w[uhcr_pkg::CAP_PARK_BIT] = uhcr_pkg::RST_CAPABILITY[uhcr_pkg::CAP_PARK_BIT];
        w[uhcr_pkg::CAP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT] = uhcr_pkg::RST_CAPABILITY[uhcr_pkg::CAP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT];
        capWord = w;
    endfunction : capWord

    // Read decode; unmapped offsets answer zero
    function automatic logic [31:0] readWord(
        input logic [15:0] a,
        input logic [31:0] cmd,
        input logic [31:0] sts,
        input logic [31:0] ien
    );
        case (a)
            uhcr_pkg::OFS_CAPABILITY_PARAMETERS: readWord = capWord();
            uhcr_pkg::OFS_CONTROLLER_COMMAND:    readWord = cmd;
            uhcr_pkg::OFS_CONTROLLER_STATUS:     readWord = sts;
            uhcr_pkg::OFS_INTERRUPT_ENABLE:      readWord = ien;
            default:                             readWord = 32'h0000_0000;
        endcase
    endfunction : readWord

    // Write decode
    assign cmdWrite  = bus.wrStb && hitReg(bus.addr, uhcr_pkg::OFS_CONTROLLER_COMMAND);
    assign stsWrite  = bus.wrStb && hitReg(bus.addr, uhcr_pkg::OFS_CONTROLLER_STATUS);
    assign intrWrite = bus.wrStb && hitReg(bus.addr, uhcr_pkg::OFS_INTERRUPT_ENABLE);

    // Light reset only when the option is built in
    generate
        if (LIGHT_RESET_IMPL) begin : g_light
            assign doLight = cmdWrite && bus.wrData[uhcr_pkg::CMD_LIGHT_BIT];
        end else begin : g_no_light
            assign doLight = 1'b0;
        end
    endgenerate
    assign doReset  = cmdWrite && bus.wrData[uhcr_pkg::CMD_RESET_BIT];
    assign anyReset = doReset || doLight;

    // Command next value; reset strobes self-clear and read zero
    always_comb begin
        next_command = command;
        if (anyReset) begin
            next_command = uhcr_pkg::RST_COMMAND;
        end else if (cmdWrite) begin
            next_command = bus.wrData;
            next_command[uhcr_pkg::CMD_RESET_BIT] = 1'b0;
            next_command[uhcr_pkg::CMD_LIGHT_BIT] = 1'b0;
        end
    end

    // Command register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            command <= uhcr_pkg::RST_COMMAND;
        end else begin
            command <= next_command;
        end
    end

    // Flag next values; any controller reset clears both
    always_comb begin
        next_rollFlag = stickyFlag(rollFlag, indexWrap,
                                   stsWrite && bus.wrData[uhcr_pkg::STS_ROLL_BIT]);
        next_portFlag = stickyFlag(portFlag, portChange || resumeDetect,
                                   stsWrite && bus.wrData[uhcr_pkg::STS_PORT_BIT]);
        if (anyReset) begin
            next_rollFlag = 1'b0;
            next_portFlag = 1'b0;
        end
    end

    // Rollover flag, sticky until cleared
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rollFlag <= uhcr_pkg::RST_STATUS[uhcr_pkg::STS_ROLL_BIT];
        end else begin
            rollFlag <= next_rollFlag;
        end
    end

    // Port change flag, sticky until cleared
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            portFlag <= uhcr_pkg::RST_STATUS[uhcr_pkg::STS_PORT_BIT];
        end else begin
            portFlag <= next_portFlag;
        end
    end

    // Status word: controller flags only, other bits reserved
    always_comb begin
        status = uhcr_pkg::RST_STATUS;
        status[uhcr_pkg::STS_ROLL_BIT] = rollFlag;
        status[uhcr_pkg::STS_PORT_BIT] = portFlag;
    end

    // Reserved enable word, no function
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            intrEnable <= uhcr_pkg::RST_INTR_ENABLE;
        end else if (intrWrite) begin
            intrEnable <= bus.wrData;
        end
    end

    // Read data, held until the next read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus.rdData <= 32'h0000_0000;
        end else if (bus.rdStb) begin
            bus.rdData <= readWord(bus.addr, command, status, intrEnable);
        end
    end

    // Read answer pulse, one cycle after the strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus.rdValid <= 1'b0;
        end else begin
            bus.rdValid <= bus.rdStb;
        end
    end

    // Schedule run level, stopped by any controller reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            runSchedule <= 1'b0;
        end else if (anyReset) begin
            runSchedule <= 1'b0;
        end else if (cmdWrite) begin
            runSchedule <= bus.wrData[uhcr_pkg::CMD_RUN_BIT];
        end
    end

    // Frame list size handed to the schedule engine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frameListSize <= 2'b00;
        end else if (anyReset) begin
            frameListSize <= 2'b00;
        end else if (cmdWrite) begin
            frameListSize <= bus.wrData[uhcr_pkg::CMD_FLS_LSB +: 2];
        end
    end

    // One-cycle reset pulses to the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coreReset  <= 1'b0;
            lightReset <= 1'b0;
        end else begin
            coreReset  <= doReset;
            lightReset <= doLight;
        end
    end
endmodule : uhcr_ctrl_regs

// >>> logic/uhcr_sw_end.sv
// Software end: issues single register reads and writes
`timescale 1ns/1ps
module uhcr_sw_end (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // User request
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [15:0] reqAddr,
    input  wire logic [31:0] reqData,
    // User answer
    output logic [31:0]      ansData,
    output logic             ansValid,
    // Register port
    uhcr_if.sw               bus
);
    logic [31:0] wdata;

    // Keep reserved bits: command gets its reset pattern, status zero, other offsets pass unchanged
    always_comb begin
        wdata = reqData;
        if (reqAddr == uhcr_pkg::OFS_CONTROLLER_COMMAND) begin
            wdata = (reqData & ~uhcr_pkg::CMD_KEEP_MASK) | uhcr_pkg::RST_COMMAND;
            wdata[uhcr_pkg::CMD_FLS_LSB +: 2] = reqData[uhcr_pkg::CMD_FLS_LSB +: 2] &
                {2{uhcr_pkg::RST_CAPABILITY[uhcr_pkg::CAP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT]}};
        end else if (reqAddr == uhcr_pkg::OFS_CONTROLLER_STATUS) begin
            wdata = reqData & 32'h0000_000C;
        end
    end

    // Registered drive of the port
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus.wrStb  <= 1'b0;
            bus.rdStb  <= 1'b0;
            bus.addr   <= 16'h0000;
            bus.wrData <= 32'h0000_0000;
            ansData    <= 32'h0000_0000;
            ansValid   <= 1'b0;
        end else begin
            bus.wrStb  <= reqValid && reqWrite;
            bus.rdStb  <= reqValid && !reqWrite;
            if (reqValid) begin
                bus.addr   <= reqAddr;
                bus.wrData <= wdata;
            end
            ansValid <= bus.rdValid;
            if (bus.rdValid) begin
                ansData <= bus.rdData;
            end
        end
    end
endmodule : uhcr_sw_end

// >>> sim/uhcr_assertions.sv
// Assertions on the register port between both ends
`timescale 1ns/1ps
module uhcr_assertions (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Register port
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [15:0] addr,
    input wire logic [31:0] wrData,
    input wire logic [31:0] rdData,
    input wire logic        rdValid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Decoded reads
    wire capRd = rdStb && addr == uhcr_pkg::OFS_CAPABILITY_PARAMETERS;
    wire cmdRd = rdStb && addr == uhcr_pkg::OFS_CONTROLLER_COMMAND;
    wire stsRd = rdStb && addr == uhcr_pkg::OFS_CONTROLLER_STATUS;
    property p_rd_answer; rdStb |=> rdValid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_cap_word; capRd |=> rdData == uhcr_pkg::RST_CAPABILITY; endproperty
    a_cap_word: assert property (p_cap_word) else $error("capability word changed");
    property p_ext_ptr; capRd |=> rdData[15:8] == uhcr_pkg::RST_EXT_PTR; endproperty
    a_ext_ptr: assert property (p_ext_ptr) else $error("pointer field wrong");
    property p_iso; capRd |=> rdData[7:4] == uhcr_pkg::RST_ISO_THRESH; endproperty
    a_iso: assert property (p_iso) else $error("threshold field wrong");
    property p_park; capRd |=> rdData[2]; endproperty
    a_park: assert property (p_park) else $error("park bit low");
    property p_programmable_frame_list_flag; capRd |=> rdData[1]; endproperty
    a_programmable_frame_list_flag: assert property (p_programmable_frame_list_flag) else $error("frame list flag low");
    property p_light; cmdRd |=> !rdData[7]; endproperty
    a_light: assert property (p_light) else $error("light reset bit reads one");
    property p_sts; stsRd |=> rdData[31:4] == 28'h0 && rdData[1:0] == 2'h0; endproperty
    a_sts: assert property (p_sts) else $error("status reserved bits set");
    // Main scenarios
    c_cap: cover property (capRd);
    c_cmd: cover property (cmdRd);
    c_sts: cover property (stsRd);
endmodule : uhcr_assertions

// >>> sim/usb_host_ctrl_cmd_status_regs_tb_top.sv
// Self-checking bench for both ends of the register port
`timescale 1ns/1ps
module usb_host_ctrl_cmd_status_regs_tb_top;
    localparam logic [15:0] CAP = uhcr_pkg::OFS_CAPABILITY_PARAMETERS;
    localparam logic [15:0] CMD = uhcr_pkg::OFS_CONTROLLER_COMMAND;
    localparam logic [15:0] STS = uhcr_pkg::OFS_CONTROLLER_STATUS;
    localparam logic [31:0] RC  = uhcr_pkg::RST_COMMAND;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic [15:0] reqAddr = 16'h0000;
    logic [31:0] reqData = 32'h0;
    logic        indexWrap = 1'b0;
    logic        portChange = 1'b0;
    logic        resumeDetect = 1'b0;
    logic [31:0] ansData, rd;
    logic        ansValid, runSchedule, coreReset, lightReset, seenCore, seenLight;
    logic [1:0]  frameListSize;
    int          mismatches = 0;
    int          comparisons = 0;
    uhcr_if bus ();
    // Both ends face each other, checker beside the port
    uhcr_ctrl_regs uhcr_ctrl_regs_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
        .indexWrap(indexWrap), .portChange(portChange), .resumeDetect(resumeDetect),
        .runSchedule(runSchedule), .frameListSize(frameListSize), .coreReset(coreReset),
        .lightReset(lightReset));
    uhcr_sw_end uhcr_sw_end_inst (.clk_sys(clk_sys), .arst_n(arst_n), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .ansData(ansData),
        .ansValid(ansValid), .bus(bus));
    uhcr_assertions uhcr_assertions_inst (.clk_sys(clk_sys), .arst_n(arst_n), .wrStb(bus.wrStb),
        .rdStb(bus.rdStb), .addr(bus.addr), .wrData(bus.wrData), .rdData(bus.rdData),
        .rdValid(bus.rdValid));
    // Clock
    always #12.5 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // One request, then a bounded wait for the answer or reset pulses
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        {reqValid, reqWrite, reqAddr, reqData} = {1'b1, wr, a, d};
        @(negedge clk_sys);
        reqValid = 1'b0;
        {seenCore, seenLight} = 2'b00;
        for (int n = 0; n < 6 && !(ansValid === 1'b1 && !wr); n++) begin
            @(negedge clk_sys);
            seenCore |= coreReset;
            seenLight |= lightReset;
        end
        if (!wr && ansValid !== 1'b1) begin
            mismatches++;
            results();
        end
        rd = ansData;
    endtask : access
    // One-cycle core event: bit 0 wrap, bit 1 port change, bit 2 resume
    task automatic pulse(input logic [2:0] ev);
        @(negedge clk_sys);
        {resumeDetect, portChange, indexWrap} = ev;
        @(negedge clk_sys);
        {resumeDetect, portChange, indexWrap} = 3'b000;
    endtask : pulse
    task automatic t_caps;
        access(1'b0, CAP, 32'h0); check(rd, uhcr_pkg::RST_CAPABILITY);
        access(1'b1, CAP, 32'hFFFF_FFFF);
        access(1'b0, CAP, 32'h0); check(rd, uhcr_pkg::RST_CAPABILITY);
        access(1'b0, 16'h0030, 32'h0); check(rd, 32'h0);
        access(1'b1, uhcr_pkg::OFS_INTERRUPT_ENABLE, 32'h0000_00A5);
        access(1'b0, uhcr_pkg::OFS_INTERRUPT_ENABLE, 32'h0); check(rd, 32'h0000_00A5);
    endtask : t_caps
    task automatic t_cmd;
        access(1'b0, CMD, 32'h0); check(rd, RC);
        access(1'b1, CMD, RC | 32'h9); check({31'h0, runSchedule}, 32'h1);
        check({30'h0, frameListSize}, 32'h2);
        access(1'b0, CMD, 32'h0); check(rd, RC | 32'h9);
        access(1'b1, CMD, RC); check({31'h0, runSchedule}, 32'h0);
    endtask : t_cmd
    task automatic t_sts;
        pulse(3'b001); access(1'b0, STS, 32'h0); check(rd, 32'h8);
        pulse(3'b010); access(1'b0, STS, 32'h0); check(rd, 32'hC);
        access(1'b1, STS, 32'h0); access(1'b0, STS, 32'h0); check(rd, 32'hC);
        access(1'b1, STS, 32'h8); access(1'b0, STS, 32'h0); check(rd, 32'h4);
        access(1'b1, STS, 32'h4); access(1'b0, STS, 32'h0); check(rd, 32'h0);
        pulse(3'b100); access(1'b0, STS, 32'h0); check(rd, 32'h4);
        // Wrap lands in the clearing write's cycle: set wins
        @(negedge clk_sys);
        {reqValid, reqWrite, reqAddr, reqData} = {1'b1, 1'b1, STS, 32'h8};
        @(negedge clk_sys);
        {reqValid, indexWrap} = 2'b01;
        @(negedge clk_sys);
        indexWrap = 1'b0;
        access(1'b0, STS, 32'h0); check(rd, 32'hC);
    endtask : t_sts
    task automatic t_resets;
        access(1'b1, CMD, RC | 32'h1); pulse(3'b001);
        access(1'b1, CMD, RC | 32'h2); check({31'h0, seenCore}, 32'h1);
        check({31'h0, runSchedule}, 32'h0);
        access(1'b0, STS, 32'h0); check(rd, 32'h0);
        access(1'b0, CMD, 32'h0); check(rd, RC);
        access(1'b1, CMD, RC | 32'h80); check({31'h0, seenLight}, 32'h1);
        access(1'b0, CMD, 32'h0); check(rd, RC);
    endtask : t_resets
    // Asynchronous reset in mid-run returns controls and command
    task automatic t_arst;
        access(1'b1, CMD, RC | 32'h5); check({30'h0, frameListSize}, 32'h1);
        @(negedge clk_sys);
        arst_n = 1'b0;
        @(negedge clk_sys);
        arst_n = 1'b1;
        check({30'h0, frameListSize}, 32'h0);
        check({31'h0, runSchedule}, 32'h0);
        access(1'b0, CMD, 32'h0); check(rd, RC);
    endtask : t_arst
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        t_caps();
        t_cmd();
        t_sts();
        t_resets();
        t_arst();
        results();
    end
endmodule : usb_host_ctrl_cmd_status_regs_tb_top
